// ==== core/ufc_map.svh ====
// register offsets, field positions, masks and reset values of the bank
`ifndef UFC_MAP_SVH
`define UFC_MAP_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define UFC_OFF_IN_EN    3'h0
`define UFC_OFF_OUT_EN   3'h1
`define UFC_OFF_SIZE_LO  3'h2
`define UFC_OFF_SIZE_HI  3'h3
`define UFC_OFF_BUF_MODE 3'h4
// ------------------------------------------------------------
// reset values and implemented-bit masks
// ------------------------------------------------------------
`define UFC_RST_VAL      8'h00
`define UFC_MASK_SIZE_LO 8'hFC
`define UFC_MASK_BUF     8'h0F
`define UFC_OUT_EP_MASK  8'hF2
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define UFC_TOG_BIT      0
`define UFC_EP2_DB_BIT   0
`define UFC_EP3_DB_BIT   2
`define UFC_SIZE_MIN     7'h08
`endif

// ==== core/ufc_pkg.sv ====
// shared types of the endpoint fifo configuration bank
package ufc_pkg;
    // software register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ufc_bus_req_t;
    // transfer events from the serial engine
    typedef struct packed {
        logic [2:0] ep;
        logic       start;
        logic       ack;
    } ufc_xfer_t;
    // configuration captured for the transfer in progress
    typedef struct packed {
        logic       inEn;
        logic       outEn;
        logic [6:0] sizeBytes;
        logic       doubleBuf;
    } ufc_ep_cfg_t;
endpackage

// ==== core/ufc_toggle_track.sv ====
// per-endpoint data toggle tracker
`timescale 1ns/100ps
module ufc_toggle_track #(
    parameter int NUM_EP = 8
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // control
    input  wire logic              startSel,
    input  wire ufc_pkg::ufc_xfer_t xfer,
    // toggle state, 1 means the next packet is DATA1
    output logic [NUM_EP-1:0]      pidVec
);
    import ufc_pkg::*;

    // load the first toggle at transfer start, flip after each ack given without a start
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pidVec <= '0;
        end else if (xfer.start) begin
            pidVec[xfer.ep] <= startSel; // RULE_04 RULE_05
        end else if (xfer.ack) begin
            pidVec[xfer.ep] <= ~pidVec[xfer.ep]; // RULE_05
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence seqStart0;
        xfer.start && !startSel;
    endsequence

    sequence seqStartAck1;
        xfer.start && startSel ##1 xfer.ack && !xfer.start
            && xfer.ep == $past(xfer.ep);
    endsequence

    AST_TOG_DATA0: assert property (@(posedge clk) disable iff (reset) // RULE_04
        seqStart0 |=> pidVec[$past(xfer.ep)] == 1'b0)
        else $error("toggle did not start at DATA0");

    AST_TOG_ALT: assert property (@(posedge clk) disable iff (reset) // RULE_05
        seqStartAck1 |=> pidVec[$past(xfer.ep)] == 1'b0)
        else $error("toggle did not alternate after DATA1");
endmodule

// ==== core/ufc_config_bank.sv ====
// endpoint fifo configuration register bank
// Overview of operation
// (RULE_01) Input enable bits 7..1 enable the input fifos of endpoints 7..1.
// (RULE_02) Output enable bits 7,6,5,4,1 enable those endpoints' out fifos.
// (RULE_03) Software writes zero to reserved output enable bits 3 and 2.
// (RULE_04) Toggle select 0 makes the next transfer start with DATA0.
// (RULE_05) Toggle select 1 starts with DATA1, then the toggle alternates.
// (RULE_06) Low size register holds 2-bit sizes for endpoints 3,2,1 (8..64).
// (RULE_07) Low size register bits 1 and 0 always read as zero.
// (RULE_08) High size register holds 2-bit sizes for endpoints 7,6,5,4.
// (RULE_09) Buffer mode bit 2 selects single or double buffer for ep3 in.
// (RULE_10) Buffer mode bit 0 selects single or double buffer for ep2 in.
// (RULE_11) Buffer bits 3,1 are written zero; bits 7..4 read as zero.
// (RULE_12) Buffer mode register is cleared only by power-on reset.
// (RULE_13) Bits read back as written and steer transfers started later.
`timescale 1ns/100ps
`include "ufc_map.svh"
module ufc_config_bank #(
    parameter int NUM_EP = 8
) (
    // clock, power-on reset and other reset source
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   sysReset,
    // register port
    input  wire ufc_pkg::ufc_bus_req_t  busReq,
    output logic [7:0]                  rdata,
    // serial engine transfer events
    input  wire ufc_pkg::ufc_xfer_t     xfer,
    // decoded per-endpoint configuration
    output logic [NUM_EP-1:0]           epInEn,
    output logic [NUM_EP-1:0]           epOutEn,
    output logic [NUM_EP-1:0][6:0]      epSizeBytes,
    output logic [NUM_EP-1:0]           epDoubleBuf,
    output logic [NUM_EP-1:0]           epDataPid,
    // configuration latched at transfer start
    output ufc_pkg::ufc_ep_cfg_t        activeCfg
);
    import ufc_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] in_enable_reg;
    logic [7:0] out_enable_reg;
    logic [7:0] size_reg_low;
    logic [7:0] size_reg_high;
    logic [7:0] buffer_mode_reg;
    logic [7:0] rdataNext;
    logic [NUM_EP-1:0][1:0] sizeSel;

    // size selector to byte count, 00..11 gives 8,16,32,64
    function automatic logic [6:0] sizeDecode(input logic [1:0] sel);
        sizeDecode = `UFC_SIZE_MIN << sel;
    endfunction

    // write strobe for one offset
    function automatic logic wrHit(input ufc_bus_req_t r,
                                   input logic [2:0] off);
        wrHit = r.wr && (r.addr == off);
    endfunction

    // bits that hold state at an offset, the rest read as zero
    function automatic logic [7:0] implMask(input logic [2:0] off);
        case (off)
            `UFC_OFF_SIZE_LO:  implMask = `UFC_MASK_SIZE_LO;
            `UFC_OFF_BUF_MODE: implMask = `UFC_MASK_BUF;
            `UFC_OFF_IN_EN,
            `UFC_OFF_OUT_EN,
            `UFC_OFF_SIZE_HI:  implMask = 8'hFF;
            default:           implMask = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // registers cleared by any reset
    // ------------------------------------------------------------
    // enable registers, all bits stored as written
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            in_enable_reg  <= `UFC_RST_VAL;
            out_enable_reg <= `UFC_RST_VAL;
        end else if (sysReset) begin
            in_enable_reg  <= `UFC_RST_VAL;
            out_enable_reg <= `UFC_RST_VAL;
        end else begin
            if (wrHit(busReq, `UFC_OFF_IN_EN)) begin
                in_enable_reg <= busReq.wdata; // RULE_01 RULE_13
            end
            if (wrHit(busReq, `UFC_OFF_OUT_EN)) begin
                out_enable_reg <= busReq.wdata; // RULE_02 RULE_13
            end
        end
    end

    // size registers, low bits 1..0 of the low register not stored
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            size_reg_low  <= `UFC_RST_VAL;
            size_reg_high <= `UFC_RST_VAL;
        end else if (sysReset) begin
            size_reg_low  <= `UFC_RST_VAL;
            size_reg_high <= `UFC_RST_VAL;
        end else begin
            if (wrHit(busReq, `UFC_OFF_SIZE_LO)) begin
                size_reg_low <= busReq.wdata & `UFC_MASK_SIZE_LO; // RULE_07
            end
            if (wrHit(busReq, `UFC_OFF_SIZE_HI)) begin
                size_reg_high <= busReq.wdata; // RULE_08
            end
        end
    end

    // ------------------------------------------------------------
    // register cleared by power-on reset only
    // ------------------------------------------------------------
    // the other reset source is deliberately not looked at here
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            buffer_mode_reg <= `UFC_RST_VAL; // RULE_12
        end else if (wrHit(busReq, `UFC_OFF_BUF_MODE)) begin
            buffer_mode_reg <= busReq.wdata & `UFC_MASK_BUF; // RULE_11
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // unmapped offsets read as zero
    always_comb begin
        case (busReq.addr)
            `UFC_OFF_IN_EN:    rdataNext = in_enable_reg;
            `UFC_OFF_OUT_EN:   rdataNext = out_enable_reg;
            `UFC_OFF_SIZE_LO:  rdataNext = size_reg_low;
            `UFC_OFF_SIZE_HI:  rdataNext = size_reg_high;
            `UFC_OFF_BUF_MODE: rdataNext = buffer_mode_reg;
            default:           rdataNext = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata <= 8'h00;
        end else if (busReq.rd) begin
            rdata <= rdataNext; // RULE_13
        end else begin
            rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // per-endpoint decode
    // ------------------------------------------------------------
    // endpoint 0 has no size field here and uses the smallest code
    always_comb begin
        sizeSel[0] = 2'b00;
        sizeSel[1] = size_reg_low[3:2];  // RULE_06
        sizeSel[2] = size_reg_low[5:4];  // RULE_06
        sizeSel[3] = size_reg_low[7:6];  // RULE_06
        sizeSel[4] = size_reg_high[1:0]; // RULE_08
        sizeSel[5] = size_reg_high[3:2]; // RULE_08
        sizeSel[6] = size_reg_high[5:4]; // RULE_08
        sizeSel[7] = size_reg_high[7:6]; // RULE_08
    end

    // enables, sizes and buffer modes seen by the fifo logic
    always_comb begin
        epInEn  = in_enable_reg; // RULE_01
        epOutEn = out_enable_reg & `UFC_OUT_EP_MASK; // RULE_02
        epDoubleBuf = '0;
        epDoubleBuf[2] = buffer_mode_reg[`UFC_EP2_DB_BIT]; // RULE_10
        epDoubleBuf[3] = buffer_mode_reg[`UFC_EP3_DB_BIT]; // RULE_09
        for (int i = 0; i < NUM_EP; i++) begin
            epSizeBytes[i] = sizeDecode(sizeSel[i]);
        end
    end

    // ------------------------------------------------------------
    // transfer snapshot
    // ------------------------------------------------------------
    // a write during a transfer only affects the next one
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            activeCfg <= '0;
        end else if (xfer.start) begin
            activeCfg.inEn      <= epInEn[xfer.ep];  // RULE_13
            activeCfg.outEn     <= epOutEn[xfer.ep];
            activeCfg.sizeBytes <= sizeDecode(sizeSel[xfer.ep]);
            activeCfg.doubleBuf <= epDoubleBuf[xfer.ep];
        end
    end

    // data toggle tracking per endpoint
    ufc_toggle_track #(
        .NUM_EP (NUM_EP)
    ) uToggle (
        .clk      (clk),
        .reset    (reset),
        .startSel (out_enable_reg[`UFC_TOG_BIT]), // RULE_04 RULE_05
        .xfer     (xfer),
        .pidVec   (epDataPid)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence seqWrThenRd;
        busReq.wr && !sysReset ##1 busReq.rd
            && busReq.addr == $past(busReq.addr);
    endsequence

    sequence seqRdLow;
        busReq.rd && busReq.addr == `UFC_OFF_SIZE_LO;
    endsequence

    sequence seqRdBuf;
        busReq.rd && busReq.addr == `UFC_OFF_BUF_MODE;
    endsequence

    AST_IN_WRITE: assert property ( // RULE_01
        busReq.wr && !sysReset && busReq.addr == `UFC_OFF_IN_EN
            |=> epInEn == $past(busReq.wdata))
        else $error("input enable not taken from write");

    AST_OUT_MAP: assert property ( // RULE_02
        epOutEn[3:2] == 2'b00 && epOutEn[0] == 1'b0
            && epOutEn[7:4] == out_enable_reg[7:4]
            && epOutEn[1] == out_enable_reg[1])
        else $error("output enable mapping wrong");

    AST_SIZE_EP3: assert property ( // RULE_06
        epSizeBytes[3] == (7'h08 << size_reg_low[7:6]))
        else $error("endpoint 3 size decode wrong");

    AST_LOW_ZERO: assert property ( // RULE_07
        seqRdLow |=> rdata[1:0] == 2'b00)
        else $error("low size bits 1..0 not zero");

    AST_SIZE_EP7: assert property ( // RULE_08
        busReq.wr && !sysReset && busReq.addr == `UFC_OFF_SIZE_HI
            |=> epSizeBytes[7] == (7'h08 << $past(busReq.wdata[7:6])))
        else $error("endpoint 7 size not from write");

    AST_DB_MAP: assert property ( // RULE_09
        epDoubleBuf[3] == buffer_mode_reg[2]
            && epDoubleBuf[2] == buffer_mode_reg[0])
        else $error("double buffer select wrong");

    AST_BUF_HIGH_ZERO: assert property ( // RULE_11
        seqRdBuf |=> rdata[7:4] == 4'h0)
        else $error("buffer mode upper bits not zero");

    AST_BUF_KEEP: assert property ( // RULE_12
        sysReset && !(busReq.wr && busReq.addr == `UFC_OFF_BUF_MODE)
            |=> $stable(buffer_mode_reg))
        else $error("buffer mode changed by non power-on reset");

    // mask follows the offset of the read, not what the bus shows later
    AST_READBACK: assert property ( // RULE_13
        seqWrThenRd |=> rdata == ($past(busReq.wdata, 2)
            & implMask($past(busReq.addr))))
        else $error("register did not read back written value");

    AST_SNAPSHOT: assert property ( // RULE_13
        xfer.start |=> activeCfg.inEn == $past(epInEn[xfer.ep]))
        else $error("transfer snapshot wrong");

    // write effects seen one cycle after the strobe, then idle read data and held input enable
    AST_OUT_WRITE: assert property ( // RULE_02
        busReq.wr && !sysReset && busReq.addr == `UFC_OFF_OUT_EN
            |=> epOutEn == ($past(busReq.wdata) & `UFC_OUT_EP_MASK))
        else $error("output enable not taken from write");

    AST_SIZE_EP1: assert property ( // RULE_06
        busReq.wr && !sysReset && busReq.addr == `UFC_OFF_SIZE_LO
            |=> epSizeBytes[1] == (7'h08 << $past(busReq.wdata[3:2])))
        else $error("endpoint 1 size not from write");

    AST_DB_WRITE: assert property ( // RULE_09 RULE_10
        busReq.wr && busReq.addr == `UFC_OFF_BUF_MODE
            |=> epDoubleBuf[3:2] == {$past(busReq.wdata[2]),
                                     $past(busReq.wdata[0])})
        else $error("double buffer select not from write");

    AST_RDATA_IDLE: assert property ( // RULE_13
        !busReq.rd |=> rdata == 8'h00)
        else $error("read data stood longer than one cycle");

    AST_IN_HOLD: assert property ( // RULE_13
        !sysReset && !(busReq.wr && busReq.addr == `UFC_OFF_IN_EN)
            |=> $stable(in_enable_reg))
        else $error("input enable changed without a write");

    // snapshot fields other than the enable
    AST_SNAP_SIZE: assert property ( // RULE_13
        xfer.start |=> activeCfg.sizeBytes == $past(epSizeBytes[xfer.ep]))
        else $error("transfer snapshot size wrong");

    AST_SNAP_BUF: assert property ( // RULE_13
        xfer.start |=> activeCfg.doubleBuf == $past(epDoubleBuf[xfer.ep]))
        else $error("transfer snapshot buffer mode wrong");
endmodule

// ==== sim/ufc_config_bank_tb.sv ====
// self-checking bench of the endpoint fifo configuration bank
`timescale 1ns/100ps
`include "ufc_map.svh"
`define CHK(nm, ex, got) begin \
    checks++; \
    if ((got) !== (ex)) begin \
        n_fail++; \
        $display("Error %s expected %0h seen %0h", nm, ex, got); \
    end \
end
module ufc_config_bank_tb;
    import ufc_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic                  clk;
    logic                  reset;
    logic                  sysReset;
    ufc_bus_req_t          busReq;
    logic [7:0]            rdata;
    ufc_xfer_t             xfer;
    logic [7:0]            epInEn;
    logic [7:0]            epOutEn;
    logic [7:0][6:0]       epSizeBytes;
    logic [7:0]            epDoubleBuf;
    logic [7:0]            epDataPid;
    ufc_ep_cfg_t           activeCfg;
    ufc_ep_cfg_t           expCfg;
    int                    n_fail;
    int                    checks;

    // design under test
    ufc_config_bank #(.NUM_EP(8)) u_ufc_config_bank (
        .clk         (clk),
        .reset       (reset),
        .sysReset    (sysReset),
        .busReq      (busReq),
        .rdata       (rdata),
        .xfer        (xfer),
        .epInEn      (epInEn),
        .epOutEn     (epOutEn),
        .epSizeBytes (epSizeBytes),
        .epDoubleBuf (epDoubleBuf),
        .epDataPid   (epDataPid),
        .activeCfg   (activeCfg)
    );

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    // one-cycle write strobe, settle past the taking edge
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
        #1;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic chk_rd(input string nm, input logic [2:0] a,
                          input logic [7:0] ex);
        @(posedge clk);
        busReq.addr <= a;
        busReq.rd   <= 1'b1;
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1;
        `CHK(nm, ex, rdata)
    endtask

    // one-cycle transfer event, outputs looked at after the taking edge
    task automatic xev(input logic [2:0] ep, input logic st, input logic ak);
        @(posedge clk);
        xfer <= '{ep: ep, start: st, ack: ak};
        @(posedge clk);
        xfer <= '0;
        #1;
    endtask

    // verdict and end of run
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        close_out();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        n_fail = 0;
        checks = 0;
        reset = 1'b1;
        sysReset = 1'b0;
        busReq = '0;
        xfer = '0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        // all registers and an unmapped offset read zero after reset
        for (int i = 0; i < 6; i++) chk_rd("resetVal", 3'(i), 8'h00);
        $display("test reset values done");
        // enables, complementary patterns with an idle cycle between writes
        reg_wr(`UFC_OFF_IN_EN, 8'hAA);
        `CHK("epInEn", 8'hAA, epInEn)
        reg_wr(`UFC_OFF_IN_EN, 8'h55);
        `CHK("epInEn", 8'h55, epInEn)
        chk_rd("inReg", `UFC_OFF_IN_EN, 8'h55);
        reg_wr(`UFC_OFF_OUT_EN, 8'hF3);
        `CHK("epOutEn", 8'hF2, epOutEn)
        chk_rd("outReg", `UFC_OFF_OUT_EN, 8'hF3);
        $display("test enables done");
        // every size code on endpoints 1..7
        for (int s = 0; s < 4; s++) begin
            reg_wr(`UFC_OFF_SIZE_LO, {2'(s), 2'(s), 2'(s), 2'b11});
            reg_wr(`UFC_OFF_SIZE_HI, {2'(s), 2'(s), 2'(s), 2'(s)});
            for (int e = 1; e < 8; e++) begin
                `CHK("epSize", 7'h08 << s, epSizeBytes[e])
            end
            chk_rd("sizeLo", `UFC_OFF_SIZE_LO, {2'(s), 2'(s), 2'(s), 2'b00});
            chk_rd("sizeHi", `UFC_OFF_SIZE_HI, {2'(s), 2'(s), 2'(s), 2'(s)});
        end
        $display("test sizes done");
        // buffer mode fields and unimplemented bits
        reg_wr(`UFC_OFF_BUF_MODE, 8'hF5);
        chk_rd("bufReg", `UFC_OFF_BUF_MODE, 8'h05);
        @(posedge clk);
        #1;
        `CHK("rdataIdle", 8'h00, rdata)
        reg_wr(`UFC_OFF_BUF_MODE, 8'h01);
        `CHK("epDoubleBuf", 8'h04, epDoubleBuf)
        reg_wr(`UFC_OFF_BUF_MODE, 8'h04);
        `CHK("epDoubleBuf", 8'h08, epDoubleBuf)
        reg_wr(3'h5, 8'hFF);
        chk_rd("unmapped", 3'h5, 8'h00);
        $display("test buffer mode done");
        // data toggle start and alternation
        reg_wr(`UFC_OFF_OUT_EN, 8'h01);
        xev(3'h1, 1'b1, 1'b0);
        `CHK("pidStart1", 8'h02, epDataPid)
        xev(3'h1, 1'b0, 1'b1);
        `CHK("pidAck", 1'b0, epDataPid[1])
        xev(3'h1, 1'b0, 1'b1);
        `CHK("pidAck", 1'b1, epDataPid[1])
        reg_wr(`UFC_OFF_OUT_EN, 8'h00);
        xev(3'h1, 1'b1, 1'b1);
        `CHK("pidStart0", 8'h00, epDataPid)
        $display("test toggle done");
        // settings captured at transfer start, later writes wait
        reg_wr(`UFC_OFF_IN_EN, 8'h08);
        reg_wr(`UFC_OFF_SIZE_LO, 8'hC0);
        xev(3'h3, 1'b1, 1'b0);
        expCfg = '{inEn: 1'b1, outEn: 1'b0, sizeBytes: 7'h40, doubleBuf: 1'b1};
        `CHK("activeCfg", expCfg, activeCfg)
        reg_wr(`UFC_OFF_IN_EN, 8'h00);
        `CHK("activeCfgHeld", expCfg, activeCfg)
        xev(3'h3, 1'b1, 1'b0);
        expCfg.inEn = 1'b0;
        `CHK("activeCfgNew", expCfg, activeCfg)
        $display("test transfer snapshot done");
        // write then read with no gap, then start then ack with no gap
        @(posedge clk);
        busReq <= '{addr: `UFC_OFF_OUT_EN, wdata: 8'h93,
                    wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq <= '{addr: `UFC_OFF_OUT_EN, wdata: 8'h93,
                    wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1;
        `CHK("outB2b", 8'h93, rdata)
        `CHK("epOutEnB2b", 8'h92, epOutEn)
        @(posedge clk);
        xfer <= '{ep: 3'h5, start: 1'b1, ack: 1'b0};
        @(posedge clk);
        xfer <= '{ep: 3'h5, start: 1'b0, ack: 1'b1};
        @(posedge clk);
        xfer <= '0;
        #1;
        `CHK("pidB2b", 1'b0, epDataPid[5])
        $display("test back to back done");
        // other reset source keeps buffer mode, write beside it lands
        reg_wr(`UFC_OFF_IN_EN, 8'hFF);
        reg_wr(`UFC_OFF_SIZE_HI, 8'hFF);
        @(posedge clk);
        sysReset <= 1'b1;
        busReq <= '{addr: `UFC_OFF_BUF_MODE, wdata: 8'h05, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        sysReset <= 1'b0;
        busReq.wr <= 1'b0;
        chk_rd("inAfterSys", `UFC_OFF_IN_EN, 8'h00);
        chk_rd("hiAfterSys", `UFC_OFF_SIZE_HI, 8'h00);
        chk_rd("bufAfterSys", `UFC_OFF_BUF_MODE, 8'h05);
        `CHK("epDoubleBuf", 8'h0C, epDoubleBuf)
        // power-on reset in mid-run clears buffer mode
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        chk_rd("bufAfterPor", `UFC_OFF_BUF_MODE, 8'h00);
        $display("test resets done");
        close_out();
    end
endmodule
